// ### buck_switching_sequencer.v
// sequencing, fault inhibit, frequency and sync control of a buck switch
//
// Function
// - undervoltage lockout blocks switching, resets soft-start
// - input overvoltage stops switching
// - fold-up halves frequency until fold-down clears
// - enable low sleeps everything, drive supply too
// - enable raises drive supply before soft-start
// - soft-start ramps reference once drive is good
// - soft-start switches slower until output nears regulation
// - short circuit lowers frequency, keeps retrying
// - overcurrent at lowest fold frequency enters burst
// - own oscillator: sync low at on, high half later
// - slaved to sync input holds sync output low
// - sync following starts no sooner than 2 ms after soft-start
// - sync input rising edge forces one off cycle, then turns switch on
// - missing sync edge reverts to internal oscillator seamlessly
// - any foldback ignores sync input, sync output low
// - drive supply below stop inhibits until above start
// - light load skips switching cycles
// - output precharged delays soft-start until discharged
// - over-temperature inhibits, resets, removes drive, auto-resumes
// - minimum off time each cycle, low input folds back
`timescale 1ns/10ps
`default_nettype none
`include "buck_seq_defines.vh"
module buck_switching_sequencer #(
  parameter PW          = 8,       // period counter width
  parameter RAMP_DIV    = 64,      // cycles per soft-start reference step
  parameter SYNC_TMO    = 200,     // master reassertion timeout, cycles
  parameter BURST_ON    = 2000,    // burst mode active cycles
  parameter BURST_OFF   = 20000,   // burst mode rest cycles
  parameter SYNC_DELAY  = `CLK_HZ / 1000 * `F_SYNC_START_MS  // 2 ms
) (
  // clock and reset
  input  wire          clk_sys_i,
  input  wire          rst_i,
  // enable and fault indications
  input  wire          enable_i,             // enable pin
  input  wire          undervoltage_lockout_i,
  input  wire          overvoltage_stop_i,   // above overvoltage stop level
  input  wire          fold_up_i,            // above fold-up level
  input  wire          fold_down_i,          // still above fold-down level
  input  wire          drive_below_stop_i,   // drive supply under stop level
  input  wire          drive_above_start_i,  // drive supply over start level
  input  wire          over_temp_i,          // thermal shutdown indication
  // loop indications
  input  wire          precharge_high_i,     // feedback above precharge level
  input  wire          short_circuit_i,      // severe overload detected
  input  wire          overcurrent_i,        // current still too high
  input  wire          low_input_i,          // input near dropout
  input  wire          skip_request_i,       // light load: skip this cycle
  input  wire          peak_reached_i,       // current loop ends on time
  // sync link
  input  wire          sync_input_i,
  output reg           sync_output_o,
  // power stage
  output reg           switch_on_o,          // power switch gate command
  output reg           gate_drive_supply_o,  // drive regulator enable
  output reg  [7:0]    soft_ref_o,           // error-amp reference ramp
  output wire          soft_done_o,          // soft-start complete
  output wire          slaved_o              // following sync input
);
  localparam SD_W = 24;            // width of long counters

  reg  [2:0]      state;           // sequencer state
  reg  [2:0]      next_state;
  reg             drive_good;      // drive supply hysteresis latch
  reg             hv_fold;         // high-input halving latch
  reg  [7:0]      ramp_cnt;        // soft-start step prescaler
  reg  [SD_W-1:0] sync_dly;        // sync-enable delay counter
  reg             sync_ok;         // sync allowed after delay
  reg  [SD_W-1:0] sync_tmo;        // cycles since last sync edge
  reg             slaved;          // period owned by sync input
  reg             sync_prev;       // last sync input sample
  reg  [SD_W-1:0] burst_cnt;       // burst on/off timer
  reg             burst_rest;      // burst rest phase
  reg  [3:0]      div;             // current period multiplier
  reg             inhibit;         // any fault blocking switching
  wire            sync_rise;       // sync input rising edge
  wire            any_fold;        // any foldback active
  wire            p_start;         // timer marks
  wire            p_half;
  wire            p_last;
  wire [PW-1:0]   period;
  wire [31:0]     ramp_last;       // final soft-start prescaler count
  wire [31:0]     burst_on_last;   // final count of the burst on phase
  wire [31:0]     burst_off_last;  // final count of the burst rest phase
  wire [31:0]     sync_dly_last;   // final count of the sync delay
  wire [31:0]     sync_tmo_last;   // final count before sync is dropped
  wire            sync_take;       // accepted sync edge, restarts period

  // scale the normal period by the divide ratio
  function [PW-1:0] scale_period;
    input [3:0]  d;
    reg   [31:0] prod;
    begin
      prod         = `PERIOD_NORM * {{28{1'b0}}, d};
      scale_period = prod[PW-1:0];
    end
  endfunction

  assign sync_rise   = sync_input_i && !sync_prev;
  assign any_fold    = (div != `DIV_FULL);
  assign period      = scale_period(div);
  assign soft_done_o = (state == `ST_RUN) || (state == `ST_BURST);
  assign slaved_o    = slaved;
  // terminal counts, kept 32 bits wide and cut on purpose where compared
  assign ramp_last      = RAMP_DIV - 1;
  assign burst_on_last  = BURST_ON - 1;
  assign burst_off_last = BURST_OFF - 1;
  assign sync_dly_last  = SYNC_DELAY - 1;
  assign sync_tmo_last  = SYNC_TMO - 1;
  // a sync edge counts only once allowed and with no foldback
  assign sync_take = sync_rise && sync_ok && !any_fold;

  // combined fault inhibit
  always @* begin
    inhibit = undervoltage_lockout_i
           || overvoltage_stop_i
           || !drive_good
           || over_temp_i;
  end

  // drive supply good latch with stop/start hysteresis
  always @(posedge clk_sys_i) begin
    if (rst_i || !enable_i || over_temp_i) begin
      drive_good <= 1'b0;
    end else if (drive_below_stop_i) begin
      drive_good <= 1'b0;
    end else if (drive_above_start_i) begin
      drive_good <= 1'b1;
    end
  end

  // high-input halving latch
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      hv_fold <= 1'b0;
    end else if (fold_up_i) begin
      hv_fold <= 1'b1;
    end else if (!fold_down_i) begin
      hv_fold <= 1'b0;
    end
  end

  // sequencer next state
  always @* begin
    next_state = state;
    case (state)
      `ST_SLEEP: begin
        if (enable_i) begin
          next_state = `ST_DRV_UP;
        end
      end
      `ST_DRV_UP: begin
        if (drive_good && !inhibit) begin
          next_state = `ST_PRECHARGE;
        end
      end
      `ST_PRECHARGE: begin
        if (!precharge_high_i) begin
          next_state = `ST_SOFT;
        end
      end
      `ST_SOFT: begin
        if (soft_ref_o == `REF_FINAL) begin
          next_state = `ST_RUN;
        end
      end
      `ST_RUN: begin
        if (div == `DIV_FOLD && overcurrent_i && p_last) begin
          next_state = `ST_BURST;
        end
      end
      `ST_BURST: begin
        if (!overcurrent_i && !burst_rest) begin
          next_state = `ST_RUN;
        end
      end
      default: begin
        next_state = `ST_SLEEP;
      end
    endcase
    if (!enable_i) begin
      next_state = `ST_SLEEP;
    end else if (inhibit && state != `ST_SLEEP) begin
      next_state = `ST_DRV_UP;
    end
  end

  // state register and gate drive supply enable
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state               <= `ST_SLEEP;
      gate_drive_supply_o <= 1'b0;
    end else begin
      state               <= next_state;
      gate_drive_supply_o <= enable_i && !over_temp_i;
    end
  end

  // soft-start reference ramp, reset outside soft-start, run and burst
  always @(posedge clk_sys_i) begin
    if (rst_i || state == `ST_SLEEP || state == `ST_DRV_UP ||
        state == `ST_PRECHARGE) begin
      soft_ref_o <= `REF_ZERO;
      ramp_cnt   <= 8'h00;
    end else if (state == `ST_SOFT) begin
      if (ramp_cnt == ramp_last[7:0]) begin
        ramp_cnt   <= 8'h00;
        soft_ref_o <= soft_ref_o + 8'h01;
      end else begin
        ramp_cnt <= ramp_cnt + 8'h01;
      end
    end
  end

  // frequency mode: soft-start, short circuit, low input, high input
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      div <= `DIV_FULL;
    end else if (p_start) begin
      if (state == `ST_SOFT && soft_ref_o < `REF_NEAR) begin
        div <= `DIV_SOFT;
      end else if (short_circuit_i || low_input_i) begin
        div <= `DIV_FOLD;
      end else if (hv_fold) begin
        div <= `DIV_HALF;
      end else begin
        div <= `DIV_FULL;
      end
    end
  end

  // burst on/off timing
  always @(posedge clk_sys_i) begin
    if (rst_i || state != `ST_BURST) begin
      burst_cnt  <= {SD_W{1'b0}};
      burst_rest <= 1'b0;
    end else if (burst_rest && burst_cnt == burst_off_last[SD_W-1:0]) begin
      burst_cnt  <= {SD_W{1'b0}};
      burst_rest <= 1'b0;
    end else if (!burst_rest && burst_cnt == burst_on_last[SD_W-1:0]) begin
      burst_cnt  <= {SD_W{1'b0}};
      burst_rest <= 1'b1;
    end else begin
      burst_cnt <= burst_cnt + 1'b1;
    end
  end

  // sync enable delay after soft-start completes
  always @(posedge clk_sys_i) begin
    if (rst_i || !soft_done_o) begin
      sync_dly <= {SD_W{1'b0}};
      sync_ok  <= 1'b0;
    end else if (sync_dly == sync_dly_last[SD_W-1:0]) begin
      sync_ok <= 1'b1;
    end else begin
      sync_dly <= sync_dly + 1'b1;
    end
  end

  // sync edge tracking and reassertion timeout
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_prev <= 1'b0;
      sync_tmo  <= {SD_W{1'b0}};
      slaved    <= 1'b0;
    end else begin
      sync_prev <= sync_input_i;
      if (!sync_ok || any_fold) begin
        slaved   <= 1'b0;
        sync_tmo <= {SD_W{1'b0}};
      end else if (sync_rise) begin
        slaved   <= 1'b1;
        sync_tmo <= {SD_W{1'b0}};
      end else if (sync_tmo == sync_tmo_last[SD_W-1:0]) begin
        slaved <= 1'b0;
      end else begin
        sync_tmo <= sync_tmo + 1'b1;
      end
    end
  end

  // period timer: a taken sync edge restarts the period at once
  period_timer #(
    .W         (PW)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .restart_i (sync_take),
    .period_i  (period),
    .start_o   (p_start),
    .half_o    (p_half),
    .last_o    (p_last)
  );

  // power switch gate: on at period start, off at peak or min-off slot
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      switch_on_o <= 1'b0;
    end else if (inhibit || !(state == `ST_SOFT || state == `ST_RUN ||
                 (state == `ST_BURST && !burst_rest))) begin
      switch_on_o <= 1'b0;
    end else if (p_start) begin
      switch_on_o <= !skip_request_i;
    end else if (p_last || peak_reached_i || sync_take) begin
      // a sync edge cuts the period short: force the off slot first
      switch_on_o <= 1'b0;
    end
  end

  // sync output: low at switch on, high half a period later
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_output_o <= 1'b0;
    end else if (slaved || any_fold || !soft_done_o) begin
      sync_output_o <= 1'b0;
    end else if (p_start) begin
      sync_output_o <= 1'b0;
    end else if (p_half) begin
      sync_output_o <= 1'b1;
    end
  end
endmodule // buck_switching_sequencer
`default_nettype wire

// ### buck_seq_defines.vh
// constants for the buck switching sequencer
`ifndef BUCK_SEQ_DEFINES_VH
`define BUCK_SEQ_DEFINES_VH
// top-level states
`define ST_SLEEP     3'h0
`define ST_DRV_UP    3'h1
`define ST_PRECHARGE 3'h2
`define ST_SOFT      3'h3
`define ST_RUN       3'h4
`define ST_BURST     3'h5
// clock rate and timing figures
`define CLK_HZ          20000000
`define F_NORM_HZ       2000000
`define F_SYNC_START_MS 2
`define PERIOD_NORM     (`CLK_HZ / `F_NORM_HZ)
// divide ratios of the period for each frequency mode
`define DIV_FULL   4'h1
`define DIV_HALF   4'h2
`define DIV_FOLD   4'h4
`define DIV_SOFT   4'h4
// soft-start reference
`define REF_ZERO   8'h00
`define REF_FINAL  8'hff
`define REF_NEAR   8'hc0
`endif

// ### period_timer.v
// switching period timer with half-period and minimum-off marks
`timescale 1ns/10ps
`default_nettype none
module period_timer #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_i,
  // control
  input  wire         restart_i,   // begin a new period now
  input  wire [W-1:0] period_i,    // period length in cycles
  // marks
  output reg          start_o,     // first cycle of a period
  output reg          half_o,      // half-period reached
  output reg          last_o       // final (off) cycle of period
);
  reg [W-1:0] count;               // position within period

  // free running counter, reloaded on restart or wrap
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      count   <= {W{1'b0}};
      start_o <= 1'b0;
      half_o  <= 1'b0;
      last_o  <= 1'b0;
    end else begin
      if (restart_i || count >= period_i - 1'b1) begin
        count   <= {W{1'b0}};
        start_o <= 1'b1;
      end else begin
        count   <= count + 1'b1;
        start_o <= 1'b0;
      end
      half_o <= (count == (period_i >> 1) - 1'b1) && !restart_i;
      last_o <= (count == period_i - 2'd2) && !restart_i;
    end
  end
endmodule // period_timer
`default_nettype wire

// ### sync_clock_source.sv
// external clock source that drives the sequencer sync input
`timescale 1ns/10ps
`default_nettype none
module sync_clock_source (
  // clock
  input  wire logic       clk_sys_i,
  // control
  input  wire logic       run_i,     // emit edges while high
  input  wire logic [7:0] period_i,  // cycles between rising edges
  // sync line
  output wire logic       sync_o
);
  logic [7:0] cnt;  // position inside the sync period
  // count off the period, changing only at falling edges
  always @(negedge clk_sys_i) begin
    if (!run_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (cnt == period_i - 8'h01) ? 8'h00 : cnt + 8'h01;
    end
  end
  // two-cycle high pulse per period; parked low when stopped
  assign sync_o = run_i && (cnt < 8'h02);
endmodule // sync_clock_source
`default_nettype wire

// ### buck_switching_sequencer_properties.sv
// port-level assertions for the buck switching sequencer
`timescale 1ns/10ps
`default_nettype none
module buck_switching_sequencer_properties #(
  parameter SYNC_TMO = 200
) (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  // watched inputs
  input wire logic       enable_i,
  input wire logic       undervoltage_lockout_i,
  input wire logic       overvoltage_stop_i,
  input wire logic       fold_up_i,
  input wire logic       drive_below_stop_i,
  input wire logic       over_temp_i,
  input wire logic       short_circuit_i,
  input wire logic       low_input_i,
  input wire logic       sync_input_i,
  // watched outputs
  input wire logic       sync_output_o,
  input wire logic       switch_on_o,
  input wire logic       gate_drive_supply_o,
  input wire logic [7:0] soft_ref_o,
  input wire logic       soft_done_o,
  input wire logic       slaved_o
);
  int unsigned on_run;  // consecutive cycles with the switch on
  int unsigned since;   // cycles since the last sync rising edge
  logic        sync_q;  // sync input one cycle back
  int unsigned fold_run;  // consecutive cycles with a fold input high
  int unsigned calm;      // cycles since a fold input was last high
  wire logic   fold_now;  // any foldback request on the inputs
  assign fold_now = fold_up_i || short_circuit_i || low_input_i;
  // helper counters for spans too long to unroll
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      on_run <= 0;
      since  <= 0;
      sync_q <= 1'b0;
      fold_run <= 0;
      calm     <= 0;
    end else begin
      fold_run <= !fold_now ? 0 :
                  (fold_run < 1000) ? fold_run + 1 : fold_run;
      calm     <= fold_now ? 0 :
                  (calm < 1000) ? calm + 1 : calm;
      sync_q <= sync_input_i;
      on_run <= switch_on_o ? on_run + 1 : 0;
      since  <= (sync_input_i && !sync_q) ? 0 :
                (since < 100000) ? since + 1 : since;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // any foldback held past a full period, so the new period is in force
  sequence fold_held;
    fold_run > 24;
  endsequence
  // reference moved up by exactly one step
  sequence ramp_step;
    soft_ref_o == $past(soft_ref_o) + 8'h01;
  endsequence
  a_sleep_all_off: assert property (!enable_i [*3] |->
    !gate_drive_supply_o && !switch_on_o && !soft_done_o)
    else $error("output active in sleep");
  a_undervoltage_lockout_blocks: assert property (undervoltage_lockout_i [*3] |->
    !switch_on_o && soft_ref_o == 8'h00) else $error("switching in lockout");
  a_ov_stops: assert property (overvoltage_stop_i [*3] |->
    !switch_on_o) else $error("switching in overvoltage");
  a_drive_inhibit: assert property (drive_below_stop_i [*4] |->
    !switch_on_o && soft_ref_o == 8'h00) else $error("drive low not inhibited");
  a_temp_shutdown: assert property (over_temp_i [*3] |->
    !switch_on_o && !gate_drive_supply_o && soft_ref_o == 8'h00)
    else $error("hot and still driving");
  a_ramp_steps: assert property (soft_ref_o != $past(soft_ref_o) |->
    ramp_step or (soft_ref_o == 8'h00)) else $error("reference jumped");
  a_ramp_after_drive: assert property (soft_ref_o == 8'h01 &&
    $past(soft_ref_o) == 8'h00 |-> gate_drive_supply_o)
    else $error("ramp began without drive supply");
  a_slaved_low: assert property (slaved_o && $past(slaved_o) |->
    !sync_output_o) else $error("sync output high while slaved");
  a_sync_turn_on: assert property (slaved_o && sync_input_i &&
    !sync_q && calm > 2 |-> ##[1:3] switch_on_o)
    else $error("sync edge gave no on");
  a_sync_timeout: assert property (since > SYNC_TMO + 3 |->
    !slaved_o) else $error("still slaved without sync edges");
  a_fold_no_sync: assert property (fold_held |->
    !slaved_o && !sync_output_o) else $error("sync used during foldback");
  a_min_off: assert property (on_run < 40)
    else $error("no off interval in period");
endmodule // buck_switching_sequencer_properties
bind buck_switching_sequencer buck_switching_sequencer_properties
  #(.SYNC_TMO(SYNC_TMO)) chk_i (.*);
`default_nettype wire

// ### tb_buck_switching_sequencer.sv
// self-checking testbench for the buck switching sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_buck_switching_sequencer;
  localparam int TMO = 60;  // shortened sync timeout
  logic       clk_sys_i, rst_i, enable, pre, fold_up, fold_dn, drv_ok;
  logic       short, ocur, lowin, skip, srun, sync_in, peak;
  logic [7:0] sper;  // period of the far-side sync clock
  logic [3:0] flt;  // lockout, overvoltage, drive low, hot
  wire        sync_output_o, switch_on_o, gate_drive_supply_o;
  wire        soft_done_o, slaved_o;
  wire  [7:0] soft_ref_o;
  int         failures, comparisons;
  // design under test with shortened counts
  buck_switching_sequencer #(.RAMP_DIV(2), .SYNC_TMO(TMO), .BURST_ON(40),
    .BURST_OFF(100), .SYNC_DELAY(50)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(enable),
    .undervoltage_lockout_i(flt[0]), .overvoltage_stop_i(flt[1]),
    .fold_up_i(fold_up), .fold_down_i(fold_dn),
    .drive_below_stop_i(flt[2]), .drive_above_start_i(drv_ok),
    .over_temp_i(flt[3]), .precharge_high_i(pre),
    .short_circuit_i(short), .overcurrent_i(ocur), .low_input_i(lowin),
    .skip_request_i(skip), .peak_reached_i(peak),
    .sync_input_i(sync_in), .sync_output_o(sync_output_o),
    .switch_on_o(switch_on_o), .gate_drive_supply_o(gate_drive_supply_o),
    .soft_ref_o(soft_ref_o), .soft_done_o(soft_done_o),
    .slaved_o(slaved_o));
  // external clock on the far side of the sync link
  sync_clock_source src (.clk_sys_i(clk_sys_i), .run_i(srun),
    .period_i(sper), .sync_o(sync_in));
  // 50 ns clock
  always #25 clk_sys_i = ~clk_sys_i;
  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // cycles until the next rising edge of the switch command
  task wait_on(output int n);
    n = 0;
    while (switch_on_o !== 1'b0 && n < 400) begin cyc(1); n++; end
    while (switch_on_o !== 1'b1 && n < 400) begin cyc(1); n++; end
  endtask
  task period(input logic [15:0] exp, input string nm);
    int n;
    wait_on(n);
    wait_on(n);
    chk(nm, exp, n[15:0]);
  endtask
  task wait_done;
    int n;
    n = 0;
    while (soft_done_o !== 1'b1 && n < 1500) begin cyc(1); n++; end
    chk("soft_done", 1, soft_done_o);
  endtask
  task t_start;
    enable = 1'b1;
    cyc(1);
    chk("gate_drive", 1, gate_drive_supply_o);
    cyc(20);
    chk("held_ref", 0, {switch_on_o, soft_ref_o});
    pre = 1'b0;
    period(40, "soft_period");
    wait_done;
    chk("final_ref", 8'hff, soft_ref_o);
  endtask
  task t_own_osc;
    period(10, "norm_period");
    chk("sync_at_on", 0, sync_output_o);
    cyc(2);
    chk("sync_early", 0, sync_output_o);
    cyc(5);
    chk("sync_half", 1, sync_output_o);
  endtask
  task t_sync;
    int n;
    srun = 1'b1;
    n = 0;
    while (slaved_o !== 1'b1 && n < 100) begin cyc(1); n++; end
    chk("slaved", 1, slaved_o);
    period(8, "sync_period");
    chk("sync_out_slaved", 0, sync_output_o);
    srun = 1'b0;
    cyc(TMO + 10);
    chk("slaved_lost", 0, slaved_o);
    period(10, "own_period");
  endtask
  task t_fold;
    srun = 1'b1;
    fold_up = 1'b1;
    cyc(30);
    chk("fold_sync", 0, {slaved_o, sync_output_o});
    period(20, "half_period");
    srun = 1'b0;
    fold_up = 1'b0;
    fold_dn = 1'b1;
    cyc(25);
    period(20, "fold_down_hold");
    fold_dn = 1'b0;
    cyc(25);
    period(10, "full_again");
    short = 1'b1;
    cyc(45);
    period(40, "short_period");
    short = 1'b0;
    lowin = 1'b1;
    cyc(45);
    period(40, "low_in_period");
    lowin = 1'b0;
    cyc(45);
    period(10, "retry_period");
  endtask
  task t_burst;
    int n, run, best;
    short = 1'b1;
    ocur = 1'b1;
    run = 0;
    best = 0;
    for (n = 0; n < 400; n++) begin
      cyc(1);
      run = (switch_on_o === 1'b0) ? run + 1 : 0;
      if (run > best) best = run;
    end
    chk("burst_rest", 1, best > 60);
    short = 1'b0;
    ocur = 1'b0;
    cyc(150);
    period(10, "burst_exit");
  endtask
  task t_skip;
    int n, h;
    skip = 1'b1;
    cyc(12);
    h = 0;
    for (n = 0; n < 30; n++) begin cyc(1); h += (switch_on_o !== 1'b0); end
    chk("skip_on", 0, h[15:0]);
    skip = 1'b0;
    period(10, "skip_end");
    peak = 1'b1;
    cyc(1);
    peak = 1'b0;
    chk("peak_off", 0, switch_on_o);
  endtask
  task t_faults;
    int i;
    for (i = 0; i < 4; i++) begin
      flt[i] = 1'b1;
      drv_ok = (i != 2);
      cyc(4);
      chk("fault_off", 0, {switch_on_o, soft_ref_o});
      chk("fault_gate", i != 3, gate_drive_supply_o);
      flt[i] = 1'b0;
      cyc(20);
      if (i == 2) chk("drive_hyst", 0, soft_ref_o);
      drv_ok = 1'b1;
      wait_done;
    end
  endtask
  task t_sleep;
    enable = 1'b0;
    cyc(2);
    chk("sleep", 0, {gate_drive_supply_o, switch_on_o, soft_done_o});
  endtask
  // watchdog: far beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    stop_test;
  end
  initial begin
    {clk_sys_i, enable, fold_up, fold_dn, short, ocur} = 6'h00;
    {lowin, skip, srun, flt} = 7'h00;
    peak = 1'b0;
    sper = 8'h08;
    {rst_i, pre, drv_ok} = 3'h7;
    failures = 0;
    comparisons = 0;
    cyc(12);
    rst_i = 1'b0;
    chk("reset_out", 0, {switch_on_o, gate_drive_supply_o});
    t_start;
    t_own_osc;
    t_sync;
    t_fold;
    t_burst;
    t_skip;
    t_faults;
    t_sleep;
    stop_test;
  end
endmodule // tb_buck_switching_sequencer
`default_nettype wire
